// ==== hw/fsc_host.sv ====
// Host-side controller for flash standby, sleep, reset and output disable
`include "fsc_defs.svh"
module fsc_host
   import fsc_pkg::*;
#(
   parameter int READY_BUSY_CYC = `FSC_READY_BUSY_CYC
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_b,
   input  wire fsc_req_t               i_req,
   output logic                        o_req_ready,
   output logic                        o_rdata_valid,
   output logic [`FSC_DATA_W-1:0]      o_rdata,
   output logic                        o_busy,
   output logic                        o_reissue,
   output logic                        o_sleeping,
   output fsc_pins_t                   o_pins,
   output logic [`FSC_DATA_W-1:0]      o_dq_out,
   output logic                        o_dq_oe,
   input  wire logic [`FSC_DATA_W-1:0] i_dq_in,
   input  wire logic                   i_ready_busy_n
);
   logic [`FSC_DATA_W:0] pin_sync;
   logic                 rb_sync;
   logic                 rb_sync_d_reg;
   logic                 rb_sync_d_next;

   fsc_sync #(.W(`FSC_DATA_W + 1)) u_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_async ({i_ready_busy_n, i_dq_in}),
      .o_sync  (pin_sync)
   );
   assign rb_sync = pin_sync[`FSC_DATA_W];

   fsc_state_t                   state_reg, state_next;
   logic [`FSC_CNT_W-1:0]        cnt_reg, cnt_next;
   logic [`FSC_CNT_W-1:0]        stable_reg, stable_next;
   fsc_pins_t                    pins_reg, pins_next;
   logic [`FSC_DATA_W-1:0]       dq_out_reg, dq_out_next;
   logic                         dq_oe_reg, dq_oe_next;
   logic [`FSC_DATA_W-1:0]       rdata_reg, rdata_next;
   logic                         rvalid_reg, rvalid_next;
   logic                         pe_run_reg, pe_run_next;
   logic                         reissue_reg, reissue_next;
   logic                         rst_busy_reg, rst_busy_next;

   localparam logic [`FSC_CNT_W-1:0] SEL_CYC =
      `FSC_CNT_W'(`FSC_SELECT_ACCESS_CYC);
   localparam logic [`FSC_CNT_W-1:0] ADDR_CYC =
      `FSC_CNT_W'(`FSC_ADDR_ACCESS_CYC);
   localparam logic [`FSC_CNT_W-1:0] SLEEP_CYC =
      `FSC_CNT_W'(`FSC_SLEEP_CYC);
   localparam logic [`FSC_CNT_W-1:0] RSTP_CYC =
      `FSC_CNT_W'(`FSC_RESET_PULSE_CYC);
   localparam logic [`FSC_CNT_W-1:0] REC_CYC =
      `FSC_CNT_W'(`FSC_RESET_RECOVERY_CYC);
   localparam logic [`FSC_CNT_W-1:0] IDLE_CYC =
      `FSC_CNT_W'(`FSC_READY_IDLE_CYC);
   localparam logic [`FSC_CNT_W-1:0] BUSY_CYC = `FSC_CNT_W'(READY_BUSY_CYC);

   always_comb begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      pins_next      = pins_reg;
      dq_out_next    = dq_out_reg;
      dq_oe_next     = 1'b0;
      rdata_next     = rdata_reg;
      rvalid_next    = 1'b0;
      pe_run_next    = pe_run_reg;
      reissue_next   = reissue_reg;
      rst_busy_next  = rst_busy_reg;
      rb_sync_d_next = rb_sync;
      // Busy release ends a tracked program or erase
      if (pe_run_reg && rb_sync && !rb_sync_d_reg) begin
         pe_run_next = 1'b0;
      end
      case (state_reg)
         FSC_ST_STANDBY: begin
            pins_next.ce_n    = 1'b1;
            pins_next.oe_n    = 1'b1;
            pins_next.we_n    = 1'b1;
            pins_next.reset_n = 1'b1;
            if (i_req.hw_reset) begin
               rst_busy_next     = pe_run_reg || !rb_sync;
               reissue_next      = pe_run_reg;
               pe_run_next       = 1'b0;
               pins_next.reset_n = 1'b0;
               cnt_next          = '0;
               state_next        = FSC_ST_RST_LOW;
            end else if (i_req.rd || i_req.wr) begin
               pins_next.addr = i_req.addr;
               pins_next.ce_n = 1'b0;
               dq_out_next    = i_req.wdata;
               cnt_next       = '0;
               if (i_req.wr) begin
                  pins_next.we_n = 1'b0;
                  dq_oe_next     = 1'b1;
                  pe_run_next    = pe_run_reg || i_req.prog_erase;
                  reissue_next   = 1'b0;
                  state_next     = FSC_ST_WRITE;
               end else begin
                  pins_next.oe_n = 1'b0;
                  state_next     = FSC_ST_SELECT;
               end
            end
         end
         FSC_ST_SELECT: begin
            cnt_next = cnt_reg + 1'b1;
            // Longer of select and address access before sampling
            if (cnt_reg >= SEL_CYC + 1'b1 && cnt_reg >= ADDR_CYC + 1'b1)
            begin
               state_next = FSC_ST_READ;
            end
         end
         FSC_ST_READ: begin
            rdata_next     = pin_sync[`FSC_DATA_W-1:0];
            rvalid_next    = 1'b1;
            pins_next.ce_n = 1'b1;
            pins_next.oe_n = 1'b1;
            state_next     = FSC_ST_STANDBY;
         end
         FSC_ST_WRITE: begin
            dq_oe_next = 1'b1;
            cnt_next   = cnt_reg + 1'b1;
            if (cnt_reg >= SEL_CYC) begin
               pins_next.we_n = 1'b1;
               pins_next.ce_n = 1'b1;
               dq_oe_next     = 1'b0;
               state_next     = FSC_ST_STANDBY;
            end
         end
         FSC_ST_RST_LOW: begin
            pins_next.ce_n    = 1'b1;
            pins_next.oe_n    = 1'b1;
            pins_next.we_n    = 1'b1;
            pins_next.reset_n = 1'b0;
            cnt_next          = cnt_reg + 1'b1;
            if (cnt_reg + 1'b1 >= RSTP_CYC) begin
               cnt_next   = '0;
               state_next = FSC_ST_RST_WT;
            end
         end
         FSC_ST_RST_WT: begin
            cnt_next = cnt_reg + 1'b1;
            if (rst_busy_reg) begin
               if (cnt_reg + 1'b1 >= BUSY_CYC && rb_sync) begin
                  pins_next.reset_n = 1'b1;
                  cnt_next          = '0;
                  state_next        = FSC_ST_RECOVER;
               end
            end else if (cnt_reg + 1'b1 >= IDLE_CYC) begin
               pins_next.reset_n = 1'b1;
               cnt_next          = '0;
               state_next        = FSC_ST_RECOVER;
            end
         end
         FSC_ST_RECOVER: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg + 1'b1 >= REC_CYC) begin
               state_next = FSC_ST_STANDBY;
            end
         end
         default: begin
            state_next = FSC_ST_STANDBY;
         end
      endcase
      // Sleep timer runs on address stability only
      if (pins_next.addr != pins_reg.addr) begin
         stable_next = '0;
      end else if (stable_reg != SLEEP_CYC) begin
         stable_next = stable_reg + 1'b1;
      end else begin
         stable_next = stable_reg;
      end
      if (!i_rst_b) begin
         state_next     = FSC_ST_STANDBY;
         cnt_next       = '0;
         stable_next    = '0;
         pins_next      = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                             reset_n: 1'b1, addr: '0};
         dq_out_next    = '0;
         dq_oe_next     = 1'b0;
         rdata_next     = '0;
         rvalid_next    = 1'b0;
         pe_run_next    = 1'b0;
         reissue_next   = 1'b0;
         rst_busy_next  = 1'b0;
         rb_sync_d_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      stable_reg    <= stable_next;
      pins_reg      <= pins_next;
      dq_out_reg    <= dq_out_next;
      dq_oe_reg     <= dq_oe_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
      pe_run_reg    <= pe_run_next;
      reissue_reg   <= reissue_next;
      rst_busy_reg  <= rst_busy_next;
      rb_sync_d_reg <= rb_sync_d_next;
   end

   assign o_req_ready   = (state_reg == FSC_ST_STANDBY);
   assign o_rdata_valid = rvalid_reg;
   assign o_rdata       = rdata_reg;
   assign o_busy        = !rb_sync || pe_run_reg;
   assign o_reissue     = reissue_reg;
   assign o_sleeping    = (stable_reg == SLEEP_CYC);
   assign o_pins        = pins_reg;
   assign o_dq_out      = dq_out_reg;
   assign o_dq_oe       = dq_oe_reg;
endmodule

// ==== hw/fsc_defs.svh ====
// Timing constants for the flash standby, sleep and reset controller
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH
`define FSC_CLK_PERIOD_NS        20
`define FSC_ADDR_ACCESS_NS       70
`define FSC_SELECT_ACCESS_NS     70
`define FSC_SLEEP_EXTRA_NS       30
`define FSC_RESET_PULSE_MIN_NS   500
`define FSC_RESET_RECOVERY_NS    50
`define FSC_READY_BUSY_NS        20000
`define FSC_READY_IDLE_NS        500
`define FSC_CEIL_CYC(ns) (((ns) + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_ADDR_ACCESS_CYC      `FSC_CEIL_CYC(`FSC_ADDR_ACCESS_NS)
`define FSC_SELECT_ACCESS_CYC    `FSC_CEIL_CYC(`FSC_SELECT_ACCESS_NS)
`define FSC_SLEEP_CYC `FSC_CEIL_CYC(`FSC_ADDR_ACCESS_NS + `FSC_SLEEP_EXTRA_NS)
`define FSC_RESET_PULSE_CYC      `FSC_CEIL_CYC(`FSC_RESET_PULSE_MIN_NS)
`define FSC_RESET_RECOVERY_CYC   `FSC_CEIL_CYC(`FSC_RESET_RECOVERY_NS)
`define FSC_READY_BUSY_CYC       `FSC_CEIL_CYC(`FSC_READY_BUSY_NS)
`define FSC_READY_IDLE_CYC       `FSC_CEIL_CYC(`FSC_READY_IDLE_NS)
`define FSC_CNT_W                16
`define FSC_ADDR_W               22
`define FSC_DATA_W               16
`endif

// ==== hw/fsc_pkg.sv ====
// Types for the flash standby, sleep and reset controller
package fsc_pkg;
   typedef enum logic [6:0] {
      FSC_ST_STANDBY = 7'h01,
      FSC_ST_SELECT  = 7'h02,
      FSC_ST_READ    = 7'h04,
      FSC_ST_WRITE   = 7'h08,
      FSC_ST_RST_LOW = 7'h10,
      FSC_ST_RST_WT  = 7'h20,
      FSC_ST_RECOVER = 7'h40
   } fsc_state_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        reset_n;
      logic [21:0] addr;
   } fsc_pins_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        hw_reset;
      logic        prog_erase;
      logic [21:0] addr;
      logic [15:0] wdata;
   } fsc_req_t;
endpackage

// ==== hw/fsc_sync.sv ====
// Two-stage synchroniser for pin inputs
module fsc_sync
   import fsc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage1_next;
   logic [W-1:0] stage2_next;

   always_comb begin
      stage1_next = i_rst_b ? i_async : '0;
      stage2_next = i_rst_b ? stage1_reg : '0;
   end

   always_ff @(posedge i_clk) begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
   end

   assign o_sync = stage2_reg;
endmodule

// ==== tb/fsc_chk.sv ====
// Assertion checker for the flash standby, sleep and reset controller
module fsc_chk
   import fsc_pkg::*;
(
   input  wire logic      i_clk,
   input  wire logic      i_rst_b,
   input  wire logic      o_req_ready,
   input  wire logic      o_rdata_valid,
   input  wire logic      o_busy,
   input  wire logic      o_sleeping,
   input  wire fsc_pins_t o_pins,
   input  wire logic      o_dq_oe,
   input  wire logic      i_ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int          rst_low;
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || o_pins.reset_n)
         rst_low <= 0;
      else
         rst_low <= rst_low + 1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_idle_deselect: assert property (
      o_req_ready |-> o_pins.ce_n && o_pins.reset_n && !o_dq_oe)
      else $error("idle not quiet");
   a_select_hold: assert property (
      $fell(o_pins.ce_n) && !o_pins.oe_n |-> !o_pins.ce_n [*4])
      else $error("select dropped too early");
   a_data_late: assert property (
      o_rdata_valid |-> !$past(o_pins.ce_n, 5))
      else $error("data taken before access time");
   a_reset_quiet: assert property (
      !o_pins.reset_n |-> o_pins.ce_n && o_pins.we_n && o_pins.oe_n)
      else $error("access in reset");
   a_reset_width: assert property (
      $rose(o_pins.reset_n) |-> rst_low >= 25)
      else $error("reset pulse too short");
   a_reset_ready: assert property (
      $rose(o_pins.reset_n) |-> $past(i_ready_busy_n, 2))
      else $error("reset released while busy");
   a_recovery_gap: assert property (
      $rose(o_pins.reset_n) |-> !o_req_ready [*3])
      else $error("recovery time skipped");
   a_sleep_stable: assert property (
      o_sleeping |-> $stable(o_pins.addr))
      else $error("sleep with moving address");
   a_sleep_entry: assert property (
      $stable(o_pins.addr) [*6] |-> o_sleeping)
      else $error("no sleep after stable address");
   a_wake_addr: assert property (
      !$stable(o_pins.addr) |-> !o_sleeping [*3])
      else $error("sleep too soon after address change");
   a_busy_seen: assert property (
      !i_ready_busy_n [*3] |=> o_busy)
      else $error("busy pin not reported");
   a_bus_oe: assert property (
      o_dq_oe |-> o_pins.oe_n)
      else $error("bus driven with output enabled");
endmodule
bind fsc_host fsc_chk u_chk (.i_clk, .i_rst_b, .o_req_ready, .o_rdata_valid,
   .o_busy, .o_sleeping, .o_pins, .o_dq_oe, .i_ready_busy_n);

// ==== tb/fsc_flash_model.sv ====
// Behavioural model of the flash device pins
module fsc_flash_model
   import fsc_pkg::*;
#(
   parameter int ACC_CYC  = 4,
   parameter int PROG_CYC = 40,
   parameter int RDY_CYC  = 10
) (
   input  wire logic        i_clk,
   input  wire fsc_pins_t   i_pins,
   output logic      [15:0] o_dq,
   output logic             o_ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int          busy_cnt = 0;
   int          acc_cnt = 0;
   logic        wr_reg = 1'b1;
   logic [15:0] word;
   // Array word fixed by address, decoded combinationally from the address pins
   assign word = i_pins.addr[15:0] ^ 16'h5a3c;
   assign o_ready_busy_n = (busy_cnt == 0);
   // Valid only when selected, enabled, out of reset and settled
   assign o_dq = (!i_pins.ce_n && !i_pins.oe_n &&
      i_pins.reset_n && acc_cnt >= ACC_CYC) ? word : ~word;
   always @(posedge i_clk) begin
      acc_cnt <= i_pins.ce_n ? 0 : acc_cnt + 1;
      wr_reg <= i_pins.we_n | i_pins.ce_n | !i_pins.reset_n;
      if (!i_pins.reset_n) begin
         if (busy_cnt > 0)
            busy_cnt <= ((busy_cnt > RDY_CYC) ? RDY_CYC : busy_cnt) - 1;
      end else if (!wr_reg && (i_pins.we_n | i_pins.ce_n)) begin
         busy_cnt <= PROG_CYC;
      end else if (busy_cnt > 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
endmodule

// ==== tb/fsc_host_tb.sv ====
// Testbench for the flash standby, sleep and reset controller
module fsc_host_tb;
   import fsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   fsc_req_t    i_req = '0;
   logic        o_req_ready, o_rdata_valid, o_busy, o_reissue, o_sleeping;
   logic        o_dq_oe, rbn;
   logic [15:0] o_rdata, o_dq_out, dq_dev, dq_bus;
   fsc_pins_t   o_pins;
   logic [15:0] exp_q[$];
   int          err_total = 0;
   int          checks_done = 0;
   always #10 i_clk = ~i_clk;
   assign dq_bus = o_dq_oe ? o_dq_out : dq_dev;
   fsc_host #(.READY_BUSY_CYC(30)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid),
      .o_rdata(o_rdata), .o_busy(o_busy), .o_reissue(o_reissue),
      .o_sleeping(o_sleeping), .o_pins(o_pins), .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe), .i_dq_in(dq_bus), .i_ready_busy_n(rbn));
   fsc_flash_model u_flash (.i_clk(i_clk), .i_pins(o_pins), .o_dq(dq_dev),
      .o_ready_busy_n(rbn));
   task automatic chk_word(input string nm, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while ((o_req_ready !== 1'b1 || o_busy !== 1'b0) && n < 3000) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 3000)
         chk_bit("ready timeout", 1'b1, 1'b0);
   endtask
   task automatic issue(input logic rd, wr, rs, pe, input logic [21:0] a);
      wait_ready();
      if (rd)
         exp_q.push_back(a[15:0] ^ 16'h5a3c);
      i_req <= '{rd, wr, rs, pe, a, a[15:0] ^ 16'h0f0f};
      @(negedge i_clk);
      i_req <= '0;
   endtask
   always @(negedge i_clk) begin
      if (o_rdata_valid === 1'b1) begin
         if (exp_q.size() == 0)
            chk_bit("spare read", 1'b0, 1'b1);
         else
            chk_word("read data", exp_q.pop_front(), o_rdata);
      end
   end
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   initial begin
      logic [31:0] r;
      void'($urandom(52));
      repeat (5) @(negedge i_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(negedge i_clk);
      chk_bit("idle ready", 1'b1, o_req_ready);
      chk_bit("idle select", 1'b1, o_pins.ce_n);
      for (int k = 0; k < 6; k++) begin
         r = $urandom;
         issue(1'b1, 1'b0, 1'b0, 1'b0, r[21:0]);
      end
      repeat (20) @(negedge i_clk);
      chk_bit("sleeping", 1'b1, o_sleeping);
      issue(1'b0, 1'b1, 1'b0, 1'b1, 22'h00_0123);
      chk_bit("awake", 1'b0, o_sleeping);
      chk_bit("write drive", 1'b1, o_dq_oe);
      chk_word("write data", 16'h0e2c, o_dq_out);
      repeat (10) @(negedge i_clk);
      chk_bit("busy after program", 1'b1, o_busy);
      issue(1'b1, 1'b0, 1'b0, 1'b0, 22'h2a_5555);
      issue(1'b0, 1'b1, 1'b0, 1'b1, 22'h10_0040);
      repeat (2) @(negedge i_clk);
      while (o_req_ready !== 1'b1)
         @(negedge i_clk);
      i_req <= '{1'b0, 1'b0, 1'b1, 1'b0, 22'h0, 16'h0};
      @(negedge i_clk);
      i_req <= '0;
      chk_bit("reset pin", 1'b0, o_pins.reset_n);
      wait_ready();
      chk_bit("reissue flag", 1'b1, o_reissue);
      issue(1'b1, 1'b0, 1'b0, 1'b0, 22'h3f_ffff);
      issue(1'b0, 1'b1, 1'b0, 1'b1, 22'h10_0040);
      issue(1'b0, 1'b0, 1'b1, 1'b0, 22'h0);
      wait_ready();
      chk_bit("reissue cleared", 1'b0, o_reissue);
      issue(1'b1, 1'b0, 1'b0, 1'b0, 22'h00_0000);
      wait_ready();
      repeat (12) @(negedge i_clk);
      chk_bit("queue empty", 1'b1, exp_q.size() == 0);
      conclude();
   end
endmodule
